// file: bench/gpm_board.sv
// board model: driven pins loop back, others take ext
// assumes pins from gpm_port, ext from the bench
`timescale 1ns/1ps
`default_nettype none
module gpm_board (
  input wire gpm_pkg::gpm_pins_t pins,
  input wire logic [7:0] ext,
  output logic [7:0] pinIn
);
  import gpm_pkg::*;
  // wire level from port drive or board source
  assign pinIn = (pins.oe & pins.out) | (~pins.oe & ext);
endmodule // gpm_board
`default_nettype wire

// file: bench/gpm_props.sv
// checker: timing relations at the port module's pins
// assumes a bind into gpm_port by port names
`timescale 1ns/1ps
`default_nettype none
module gpm_props (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hwStandby,
  input wire logic swStandby,
  input wire logic [15:0] wb_adr_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  input wire gpm_pkg::gpm_periph_t periph,
  input wire gpm_pkg::gpm_pins_t pins,
  input wire logic [7:0] pinIn,
  input wire logic timerBResetIn
);
  import gpm_pkg::*;
  // one clock domain, reset disables all
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_dir; wb_ack_o && $past(!wb_we_i && wb_adr_i==16'hFFB5) |-> wb_dat_o==32'hFF; endproperty
  a_dir: assert property (p_dir) else $error("dir read");
  property p_hw; hwStandby[*2] |=> pins.oe[3:0]==4'h0; endproperty
  a_hw: assert property (p_hw) else $error("hw standby");
  property p_pwm; !swStandby && periph.pwmEnB |=> pins.oe[7] && pins.out[7]==$past(periph.pwmOutB); endproperty
  a_pwm: assert property (p_pwm) else $error("pwm pin");
  property p_tmr; !periph.counterClearSelLo |=> !timerBResetIn; endproperty
  a_tmr: assert property (p_tmr) else $error("timer reset");
  property p_trs; !swStandby && periph.counterClearSelHi && periph.counterClearSelLo && $past(pinIn[5], 2) |=> timerBResetIn; endproperty
  a_trs: assert property (p_trs) else $error("timer reset missing");
  property p_sw; swStandby |=> !timerBResetIn; endproperty
  a_sw: assert property (p_sw) else $error("sw standby");
  property p_cmp; !swStandby && |periph.timerOutputSelect |=> pins.oe[4]; endproperty
  a_cmp: assert property (p_cmp) else $error("compare pin");
  property p_irq; $past(periph.hostIfaceEnable && !swStandby) && pins.oe[5] |-> pins.out[5]==$past(periph.hostIrqReqB); endproperty
  a_irq: assert property (p_irq) else $error("irq pin");
  property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o && wb_adr_i==16'hFFB7 |=> wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("no ack");
endmodule // gpm_props
`default_nettype wire

// file: bench/tb.sv
// bench top: bus master, board and peripheral controls
// assumes gpm_port, gpm_board, gpm_props compiled first
`timescale 1ns/1ps
`default_nettype none
module tb;
  import gpm_pkg::*;
  logic clk=0, rst_n=0, hwS=0, swS=0, cyc=0, we=0, ack, err, tbr;
  logic [15:0] adr=0;
  logic [31:0] dw=0, dr;
  logic [7:0] ext=0, pinIn, r, d;
  gpm_periph_t per='0;
  gpm_pins_t pins;
  logic [8:0] q[$];
  int bad_count=0, total_checks=0, cycN=0;
  always #5 clk = ~clk;
  gpm_port uut(.clk(clk), .rst_n(rst_n), .hwStandby(hwS), .swStandby(swS), .wb_adr_i(adr),
    .wb_dat_i(dw), .wb_dat_o(dr), .wb_we_i(we), .wb_sel_i(4'hF), .wb_cyc_i(cyc),
    .wb_stb_i(cyc), .wb_ack_o(ack), .wb_err_o(err), .periph(per), .pinIn(pinIn),
    .pins(pins), .timerBResetIn(tbr));
  gpm_board brd(.pins(pins), .ext(ext), .pinIn(pinIn));
  task automatic test_done;
    $display("checks %0d errors %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [8:0] g, input logic [8:0] e);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // one classic cycle, read notes its expectation
  task automatic bus(input logic w, input logic [15:0] a, input logic [7:0] v, input logic [8:0] e);
    if (!w) q.push_back(e);
    @(posedge clk);
    cyc <= 1;
    we <= w;
    adr <= a;
    dw <= {24'h0, v};
    do @(posedge clk); while (!(ack | err));
    cyc <= 0;
  endtask
  // expected port read from registers, board and peripherals
  function automatic logic [7:0] pv(input logic [7:0] r, d, e, input gpm_periph_t p, input logic s);
    pv = (d & r) | (e & ~r);
    if (!s && p.pwmEnB && !r[7]) pv[7] = p.pwmOutB;
    if (!s && p.pwmEnA && !r[6]) pv[6] = p.pwmOutA;
    if (!s && |p.timerOutputSelect && !r[4]) pv[4] = p.timerBCompareOut;
  endfunction
  // read answers checked in order
  always @(posedge clk) if ((ack | err) && !we) chk({err, err ? 8'h00 : dr[7:0]}, q.pop_front());
  always @(posedge clk) begin
    cycN++;
    if (cycN == 20000) begin
      bad_count++;
      test_done;
    end
  end
  initial begin
    void'($urandom(63243));
    repeat (5) @(posedge clk);
    rst_n <= 1;
    bus(0, 16'hFFB5, 0, 9'h0FF);
    bus(0, 16'hFFB7, 0, 9'h000);
    bus(0, 16'hFFB6, 0, 9'h100);
    for (int i = 0; i < 24; i++) begin
      r = $urandom;
      d = $urandom;
      ext <= $urandom;
      per <= $urandom;
      swS <= i[0];
      bus(1, 16'hFFB5, r, 0);
      bus(1, 16'hFFB7, d, 0);
      bus(0, 16'hFFB5, 0, 9'h0FF);
      repeat (4) @(posedge clk);
      bus(0, 16'hFFB7, 0, {1'b0, pv(r, d, ext, per, swS)});
    end
    per <= '0;
    hwS <= 1;
    repeat (2) @(posedge clk);
    hwS <= 0;
    repeat (4) @(posedge clk);
    bus(0, 16'hFFB7, 0, {1'b0, ext});
    bus(1, 16'hFFB5, 8'hFF, 0);
    bus(0, 16'hFFB7, 0, 9'h000);
    test_done;
  end
endmodule // tb
bind gpm_port gpm_props u_props(.*);
`default_nettype wire

// file: hw/gpm_consts.svh
// constants for the eight-bit port with timer pin sharing
// assumes inclusion by the port module
`ifndef GPM_CONSTS_SVH
`define GPM_CONSTS_SVH
`define GPM_ADDR_DIR 16'hFFB5
`define GPM_ADDR_DATA 16'hFFB7
`define GPM_RST_DIR 8'h00
`define GPM_RST_DATA 8'h00
`define GPM_DIR_READ 8'hFF
`define GPM_BIT_PWM_B 7
`define GPM_BIT_PWM_A 6
`define GPM_BIT_IRQ_B 5
`define GPM_BIT_CMP 4
`define GPM_CCLR_ALL 2'h3
`define GPM_OS_NONE 4'h0
`endif

// file: hw/gpm_pkg.sv
// types for the eight-bit port with timer pin sharing
// assumes gpm_consts.svh is found on the include path
package gpm_pkg;
  // peripheral controls arriving from timer and system units
  typedef struct packed {
    logic pwmEnB;
    logic pwmEnA;
    logic pwmOutB;
    logic pwmOutA;
    logic [3:0] timerOutputSelect;
    logic counterClearSelHi;
    logic counterClearSelLo;
    logic timerBCompareOut;
    logic hostIfaceEnable;
    logic hostIrqReqB;
    logic hostIrqReqA;
  } gpm_periph_t;
  // pin drive group
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } gpm_pins_t;
endpackage

// file: hw/gpm_port.sv
// eight-bit general-purpose port with PWM, timer and host irq sharing
// assumes a classic Wishbone master on clk and pins sampled via two flops
// How it works
// - direction bit one drives pin, zero inputs
// - direction register reads all ones
// - direction cleared by reset and hardware standby
// - direction kept through software standby
// - software standby returns pins to general use
// - output pins read back data register
// - input pins read synchronised pin level
// - data register cleared by reset and hardware standby, kept in software standby
// - pins 7,6 drive PWM when enabled
// - pin 5 output or host irq b
// - pin 5 high resets timer b when both clear selects set
// - slave mode follows host interface enable
`timescale 1ns/1ps
`default_nettype none
`include "gpm_consts.svh"
module gpm_port #(
  parameter int ADDR_W = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hwStandby,
  input wire logic swStandby,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic wb_ack_o,
  output logic wb_err_o,
  input wire gpm_pkg::gpm_periph_t periph,
  input wire logic [7:0] pinIn,
  output gpm_pkg::gpm_pins_t pins,
  output logic timerBResetIn
);
  import gpm_pkg::*;

  initial begin
    if (ADDR_W < 16) $error("gpm_port needs at least 16 address bits");
  end

  logic [7:0] portDirectionReg_ff;
  logic [7:0] portDataReg_ff;
  logic [7:0] pinMeta_ff;
  logic [7:0] pinSync_ff;
  logic [31:0] rdData_ff;
  logic ack_ff;
  logic err_ff;
  gpm_pins_t pins_ff;
  logic timerReset_ff;
  logic req;
  logic hitDir;
  logic hitData;
  logic wrLane0;
  logic slaveMode;
  logic periphLive;
  logic [7:0] readPort;
  gpm_pins_t nxt_pins;

  // bus decode, one request per handshake
  assign req = wb_cyc_i && wb_stb_i && !ack_ff && !err_ff;
  assign hitDir = (wb_adr_i[15:0] == `GPM_ADDR_DIR);
  assign hitData = (wb_adr_i[15:0] == `GPM_ADDR_DATA);
  assign wrLane0 = req && wb_we_i && wb_sel_i[0];
  assign slaveMode = periph.hostIfaceEnable;
  assign periphLive = !swStandby; // peripherals held initialised in sw standby

  // two-flop pin synchroniser
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pinMeta_ff <= 8'h00;
      pinSync_ff <= 8'h00;
    end else begin
      pinMeta_ff <= pinIn;
      pinSync_ff <= pinMeta_ff;
    end
  end

  // direction register
  always_ff @(posedge clk) begin
    if (!rst_n || hwStandby) begin
      portDirectionReg_ff <= `GPM_RST_DIR;
    end else if (wrLane0 && hitDir) begin
      portDirectionReg_ff <= wb_dat_i[7:0]; // no swStandby clear
    end
  end

  // data register
  always_ff @(posedge clk) begin
    if (!rst_n || hwStandby) begin
      portDataReg_ff <= `GPM_RST_DATA;
    end else if (wrLane0 && hitData) begin
      portDataReg_ff <= wb_dat_i[7:0];
    end
  end

  // port read: data for outputs, pin level for inputs
  assign readPort = (portDirectionReg_ff & portDataReg_ff)
                  | (~portDirectionReg_ff & pinSync_ff);

  // bus answer one cycle after request
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ack_ff <= 1'b0;
      err_ff <= 1'b0;
      rdData_ff <= 32'h0000_0000;
    end else begin
      ack_ff <= req && (hitDir || hitData);
      err_ff <= req && !(hitDir || hitData);
      if (req && hitDir) begin
        rdData_ff <= {24'h00_0000, `GPM_DIR_READ};
      end else if (req && hitData) begin
        rdData_ff <= {24'h00_0000, readPort};
      end else begin
        rdData_ff <= 32'h0000_0000;
      end
    end
  end

  // pin function mux
  always_comb begin
    nxt_pins.out = portDataReg_ff;
    nxt_pins.oe = portDirectionReg_ff;
    if (periphLive && periph.pwmEnB) begin
      nxt_pins.out[`GPM_BIT_PWM_B] = periph.pwmOutB;
      nxt_pins.oe[`GPM_BIT_PWM_B] = 1'b1;
    end
    if (periphLive && periph.pwmEnA) begin
      nxt_pins.out[`GPM_BIT_PWM_A] = periph.pwmOutA;
      nxt_pins.oe[`GPM_BIT_PWM_A] = 1'b1;
    end
    if (periphLive && slaveMode && portDirectionReg_ff[`GPM_BIT_IRQ_B]) begin
      nxt_pins.out[`GPM_BIT_IRQ_B] = periph.hostIrqReqB;
    end
    if (periphLive && (periph.timerOutputSelect != `GPM_OS_NONE)) begin
      nxt_pins.out[`GPM_BIT_CMP] = periph.timerBCompareOut;
      nxt_pins.oe[`GPM_BIT_CMP] = 1'b1;
    end else if (periphLive && slaveMode && portDirectionReg_ff[`GPM_BIT_CMP]) begin
      nxt_pins.out[`GPM_BIT_CMP] = periph.hostIrqReqA;
    end
  end

  // registered pin drive and timer reset feed
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pins_ff <= '0;
      timerReset_ff <= 1'b0;
    end else begin
      pins_ff <= nxt_pins;
      timerReset_ff <= periphLive
        && ({periph.counterClearSelHi, periph.counterClearSelLo} == `GPM_CCLR_ALL)
        && pinSync_ff[`GPM_BIT_IRQ_B];
    end
  end

  assign pins = pins_ff;
  assign timerBResetIn = timerReset_ff;
  assign wb_ack_o = ack_ff;
  assign wb_err_o = err_ff;
  assign wb_dat_o = rdData_ff;
endmodule // gpm_port
`default_nettype wire
